//--- verilog/exd_datapath.sv
// exponent datapath, mode flags, microbreak and step counter
//
// Added by the designer: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
module exd_datapath
  import exd_pkg::*;
#(
  parameter logic [255:0] DEC_ROM_A_IMAGE = 256'h0,
  parameter logic [255:0] DEC_ROM_B_IMAGE = 256'h0
) (
  input  wire logic        clock_i,
  input  wire logic        sys_rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [59:0] microword_i,
  input  wire logic        exponent_mux_sel_hi_i,
  input  wire logic        exponent_mux_sel_lo_i,
  input  wire logic [3:0]  alu_func_i,
  input  wire logic        alu_mode_i,
  input  wire logic        alu_carry_n_i,
  input  wire logic [15:0] exponent_accum_i,
  input  wire logic        time_state_three_i,
  input  wire logic        time_state_four_i,
  input  wire logic        time_pulse_four_i,
  input  wire logic        ready_state_i,
  input  wire logic [15:0] cpu_address_mux_lines_i,
  input  wire logic [15:0] cpu_data_in_i,
  input  wire logic [15:0] b_side_mux_bus_i,
  input  wire logic        host_load_a_i,
  input  wire logic        mode_update_i,
  input  wire logic        microbreak_load_i,
  input  wire logic [7:0]  microaddress_reg_i,
  input  wire logic        step_load_i,
  input  wire logic        step_inc_i,
  input  wire logic        op_add_i,
  input  wire logic        op_sub_i,
  input  wire logic        sign_a_i,
  input  wire logic        sign_b_i,
  input  wire logic        drive_bus_i,
  input  wire logic [15:0] shared_internal_bus_i,
  output logic      [15:0] shared_internal_bus_o,
  output logic             shared_internal_bus_oe_n_o,
  output logic      [15:0] exponent_alu_o,
  output logic             exponent_alu_carry_o,
  output logic      [11:0] fp_instruction_reg_o,
  output logic      [7:0]  decode_rom_a_o,
  output logic      [7:0]  decode_rom_b_o,
  output logic             branch_select_bit5_o,
  output logic             branch_select_bit6_o,
  output logic      [2:0]  range_code_o,
  output logic             fraction_subtract_o,
  output logic             upper_byte_zero_flag_o,
  output logic             word_negative_flag_o,
  output logic             word_zero_flag_o,
  output logic             double_precision_flag_o,
  output logic             long_integer_flag_o,
  output logic             match_request_o,
  output logic             match_sync_o,
  output logic      [5:0]  shift_step_count_o,
  output logic             step_done_flag_o,
  output logic             step_upper_ones_o,
  output logic             step_preload_hold_o
);

  exd_state_t st;
  exd_state_t next_st;

  // one 4-bit ALU slice with carry in and out
  function automatic logic [4:0] alu_slice(input logic [3:0] a,
                                           input logic [3:0] b,
                                           input logic [3:0] s,
                                           input logic       m,
                                           input logic       c);
    logic [3:0] x;
    logic [3:0] y;
    logic [4:0] sum;
    x   = a | (b & {4{s[0]}}) | (~b & {4{s[1]}});
    y   = (a & b & {4{s[3]}}) | (a & ~b & {4{s[2]}});
    sum = {1'b0, x} + {1'b0, y} + {4'h0, c};
    return m ? {1'b0, ~(x ^ y)} : sum;
  endfunction

  // constant field to constant word
  function automatic logic [15:0] const_decode(input logic [4:0] f);
    logic [15:0] k;
    logic        b15;
    logic        seventy;
    b15     = (f == CF_ELEVEN) || (f == CF_FIFTEEN);
    seventy = f[4] & f[3] & f[1];
    k       = 16'h0000;
    // bit 15 versus odd bit 0
    k[15]   = b15;
    k[0]    = f[0] & ~b15;
    k[1]    = f[1] & ~seventy;
    k[2]    = f[2];
    k[3]    = (f[3] & ~b15) | seventy;
    k[4]    = f[4];
    k[5]    = seventy;
    // fields 0 and 20 add bit 7
    k[7]    = (f == CF_ZERO) || (f == CF_TWENTY);
    return k;
  endfunction

  // range code: sign plus magnitude class
  function automatic logic [2:0] range_class(input logic [9:0] d);
    logic [9:0] mag;
    logic [1:0] cls;
    mag = d[9] ? 10'(~d + 10'h001) : d;
    if (mag == 10'h000) begin
      cls = 2'h0;
    end else if (mag <= RANGE_SMALL) begin
      cls = 2'h1;
    end else if (mag <= RANGE_LARGE) begin
      cls = 2'h2;
    end else begin
      cls = 2'h3;
    end
    return {d[9], cls};
  endfunction

  always_comb begin
    logic [15:0] muxed_input_data;
    logic [15:0] rom_constant;
    logic [15:0] exponent_input_mux;
    logic [15:0] exponent_alu;
    logic [4:0]  slice;
    logic        carry;
    logic        load_a;
    logic        load_b;
    logic        hit;
    logic        wr;
    logic [31:0] rd;
    logic [5:0]  step_next;
    logic        maint_load;
    logic        inc_to_ones;
    muxed_input_data   = 16'h0000;
    rom_constant       = 16'h0000;
    exponent_input_mux = 16'h0000;
    exponent_alu       = 16'h0000;
    slice              = 5'h00;
    carry              = 1'b0;
    load_a             = 1'b0;
    load_b             = 1'b0;
    hit                = 1'b0;
    wr                 = 1'b0;
    rd                 = 32'h0000_0000;
    step_next          = st.step;
    maint_load         = 1'b0;
    inc_to_ones        = 1'b0;
    next_st            = st;

    muxed_input_data = ready_state_i ? cpu_address_mux_lines_i : cpu_data_in_i;
    rom_constant = const_decode(microword_i[MW_CONST_HI:MW_CONST_LO]);

    unique case ({exponent_mux_sel_hi_i, exponent_mux_sel_lo_i})
      2'b00: exponent_input_mux = st.hold_a;
      2'b01: exponent_input_mux = muxed_input_data;
      2'b10: exponent_input_mux = rom_constant;
      2'b11: exponent_input_mux = {10'h000, st.step};
    endcase

    carry = ~alu_carry_n_i;
    for (int i = 0; i < 4; i++) begin
      slice = alu_slice(exponent_accum_i[4*i +: 4], exponent_input_mux[4*i +: 4],
                        alu_func_i, alu_mode_i, carry);
      exponent_alu[4*i +: 4] = slice[3:0];
      carry = slice[4];
    end
    next_st.alu_q    = exponent_alu;
    next_st.alu_cout = carry;

    // range class of ALU bits 9..0
    next_st.range_q = range_class(exponent_alu[9:0]);

    next_st.frac_sub = (op_add_i & (sign_a_i ^ sign_b_i))
                     | (op_sub_i & ~(sign_a_i ^ sign_b_i));

    load_b = time_state_four_i & ~microword_i[MW_LOAD_B];
    load_a = time_state_four_i & ~microword_i[MW_LOAD_A];
    if (load_b) begin
      next_st.hold_b = b_side_mux_bus_i;
    end
    if (load_a || host_load_a_i) begin
      next_st.hold_a = b_side_mux_bus_i;
    end
    if (load_a || load_b) begin
      next_st.upper_zero = (b_side_mux_bus_i[15:8] == 8'h00);
      next_st.word_neg   = b_side_mux_bus_i[15];
      next_st.word_zero  = (b_side_mux_bus_i == 16'h0000);
    end

    if (time_state_three_i && !microword_i[MW_LOAD_INSTR]) begin
      next_st.fp_instruction_reg     = cpu_data_in_i[11:0];
      // major opcode must be all ones
      next_st.illegal = (cpu_data_in_i[15:12] != OPC_MAJOR);
    end

    // two 32 x 8 decode ROMs
    next_st.rom_a_q = DEC_ROM_A_IMAGE[{st.fp_instruction_reg[11:7], 3'h0} +: 8];
    next_st.rom_b_q = DEC_ROM_B_IMAGE[{st.fp_instruction_reg[6:2], 3'h0} +: 8];
    next_st.br5 = DEC_ROM_A_IMAGE[{st.fp_instruction_reg[11:7], 3'h5}] & ~st.illegal;
    next_st.br6 = DEC_ROM_B_IMAGE[{st.fp_instruction_reg[6:2], 3'h6}] & ~st.illegal;

    if (time_state_four_i && mode_update_i) begin
      if (st.fp_instruction_reg[6]) begin
        // load status from ALU bits 6,7
        next_st.lng = exponent_alu[6];
        next_st.dbl = exponent_alu[7];
      end else begin
        // low opcode bits pick the flag
        if (!st.fp_instruction_reg[1]) begin
          next_st.dbl = st.fp_instruction_reg[2];
        end
        if (!st.fp_instruction_reg[0]) begin
          next_st.lng = st.fp_instruction_reg[2];
        end
      end
    end

    if (microbreak_load_i) begin
      next_st.ubreak = exponent_alu[7:0];
    end
    next_st.match_req = (st.ubreak == microaddress_reg_i);
    // sync copy taken with the buffer
    if (time_state_four_i) begin
      next_st.match_sync = (st.ubreak == microaddress_reg_i);
    end

    next_st.bus_q    = drive_bus_i ? st.hold_b : 16'h0000;
    next_st.bus_oe_n = ~drive_bus_i;

    // register bus slave
    hit = wb_cyc_i & wb_stb_i & (st.wb_state == WB_IDLE);
    wr  = hit & wb_we_i & wb_sel_i[0];
    unique case ({wb_adr_i[7:2], 2'b00})
      REG_CTRL_OFF:   rd = {31'h0, st.maint_mode};
      REG_STEP_OFF:   rd = {23'h0, st.preload_hold, st.step_upper, st.step_done,
                            st.step};
      REG_STATUS_OFF: rd = {24'h0, st.illegal, st.match_sync, st.lng, st.dbl,
                            st.upper_zero, st.word_neg, st.word_zero, st.frac_sub};
      REG_HOLD_OFF:   rd = {st.hold_b, st.hold_a};
      REG_INSTR_OFF:  rd = {shared_internal_bus_i, 3'h0, st.illegal, st.fp_instruction_reg};
      REG_BREAK_OFF:  rd = {24'h0, st.ubreak};
      default:        rd = 32'h0000_0000;
    endcase
    unique case (st.wb_state)
      WB_IDLE: begin
        if (hit) begin
          next_st.wb_state = WB_ACK;
          next_st.wb_ack   = 1'b1;
          next_st.wb_dat   = wb_we_i ? 32'h0000_0000 : rd;
        end
      end
      WB_ACK: begin
        next_st.wb_state = WB_IDLE;
        next_st.wb_ack   = 1'b0;
        next_st.wb_dat   = 32'h0000_0000;
      end
    endcase
    if (wr && ({wb_adr_i[7:2], 2'b00} == REG_CTRL_OFF)) begin
      next_st.maint_mode = wb_dat_i[0];
    end
    maint_load = wr && ({wb_adr_i[7:2], 2'b00} == REG_STEP_OFF);

    // step counter: microprogram load, maintenance load, count
    if (time_pulse_four_i && step_load_i && !st.preload_hold) begin
      step_next = ~exponent_alu[5:0];
    end else if (maint_load) begin
      // complement of GR4 low six bits
      step_next = ~wb_dat_i[5:0];
    end else if (step_inc_i) begin
      step_next   = 6'(st.step + 6'h01);
      inc_to_ones = (step_next == STEP_ALL_ONES);
    end
    next_st.step = step_next;
    next_st.step_done  = (step_next == STEP_ALL_ONES);
    next_st.step_upper = (step_next[5:2] == 4'hF);
    // hold set wins over its clear
    if (maint_load && st.maint_mode) begin
      next_st.preload_hold = 1'b1;
    end else if (inc_to_ones || !next_st.maint_mode) begin
      next_st.preload_hold = 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      st <= EXD_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign wb_dat_o                   = st.wb_dat;
  assign wb_ack_o                   = st.wb_ack;
  assign shared_internal_bus_o      = st.bus_q;
  assign shared_internal_bus_oe_n_o = st.bus_oe_n;
  assign exponent_alu_o             = st.alu_q;
  assign exponent_alu_carry_o       = st.alu_cout;
  assign fp_instruction_reg_o       = st.fp_instruction_reg;
  assign decode_rom_a_o             = st.rom_a_q;
  assign decode_rom_b_o             = st.rom_b_q;
  assign branch_select_bit5_o       = st.br5;
  assign branch_select_bit6_o       = st.br6;
  assign range_code_o               = st.range_q;
  assign fraction_subtract_o        = st.frac_sub;
  assign upper_byte_zero_flag_o     = st.upper_zero;
  assign word_negative_flag_o       = st.word_neg;
  assign word_zero_flag_o           = st.word_zero;
  assign double_precision_flag_o    = st.dbl;
  assign long_integer_flag_o        = st.lng;
  assign match_request_o            = st.match_req;
  assign match_sync_o               = st.match_sync;
  assign shift_step_count_o         = st.step;
  assign step_done_flag_o           = st.step_done;
  assign step_upper_ones_o          = st.step_upper;
  assign step_preload_hold_o        = st.preload_hold;

endmodule

//--- verilog/exd_pkg.sv
// package for the exponent datapath and control block
// How it works
// - four-way exponent mux, two select bits
// - 16-bit ALU of four 4-bit slices
// - constant field from microword bits 57..53
// - listed fields map to special octal constants
// - bit15, bit0, bit3 decode per field group
// - seventy enable sets bits 5,4,3
// - output holding loads at TS4 end, bit49 low
// - input holding loads at TS4 end or host
// - instruction register captures at TS3 end, bit59 low
// - two decode ROMs, 32 words of 8 bits
// - upper-zero, negative, zero flags of loaded word
// - flags clocked at TS4 end on either load
// - range ROM classifies ALU bits 9..0 into 3 bits
// - subtract on unlike-sign add or like-sign subtract
// - opcode bits 15..12 not all ones forces branches low
// - load-status sets flags from ALU bits 6,7
// - set-mode uses opcode bits 2,1,0
// - microbreak register compare raises match request
// - match copy held for whole matching state
// - ready state passes address lines, else data
// - output register drives shared bus open-collector
// - step counter loads complement of ALU bits 5..0
// - done at all ones, upper-four-ones indication
// - maintenance load holds off microprogram loads
// - maintenance load complements GR4 low six bits
package exd_pkg;

  localparam logic [7:0] REG_CTRL_OFF   = 8'h00;
  localparam logic [7:0] REG_STEP_OFF   = 8'h04;
  localparam logic [7:0] REG_STATUS_OFF = 8'h08;
  localparam logic [7:0] REG_HOLD_OFF   = 8'h0C;
  localparam logic [7:0] REG_INSTR_OFF  = 8'h10;
  localparam logic [7:0] REG_BREAK_OFF  = 8'h14;

  localparam int MW_CONST_HI  = 57;
  localparam int MW_CONST_LO  = 53;
  localparam int MW_LOAD_B    = 49;
  localparam int MW_LOAD_A    = 48;
  localparam int MW_LOAD_INSTR = 59;

  localparam logic [4:0] CF_ZERO    = 5'h00;
  localparam logic [4:0] CF_ELEVEN  = 5'h09;
  localparam logic [4:0] CF_FIFTEEN = 5'h0D;
  localparam logic [4:0] CF_TWENTY  = 5'h10;
  localparam logic [3:0] OPC_MAJOR  = 4'hF;
  localparam logic [5:0] STEP_ALL_ONES = 6'h3F;

  localparam logic [9:0] RANGE_SMALL = 10'h018;
  localparam logic [9:0] RANGE_LARGE = 10'h038;

  typedef enum logic [0:0] {
    WB_IDLE = 1'b0,
    WB_ACK  = 1'b1
  } exd_wb_state_t;

  typedef struct packed {
    exd_wb_state_t wb_state;
    logic          wb_ack;
    logic [31:0]   wb_dat;
    logic          maint_mode;
    logic [15:0]   hold_a;
    logic [15:0]   hold_b;
    logic          upper_zero;
    logic          word_neg;
    logic          word_zero;
    logic [11:0]   fp_instruction_reg;
    logic          illegal;
    logic          dbl;
    logic          lng;
    logic [7:0]    ubreak;
    logic          match_req;
    logic          match_sync;
    logic [5:0]    step;
    logic          step_done;
    logic          step_upper;
    logic          preload_hold;
    logic [15:0]   alu_q;
    logic          alu_cout;
    logic [7:0]    rom_a_q;
    logic [7:0]    rom_b_q;
    logic          br5;
    logic          br6;
    logic [2:0]    range_q;
    logic          frac_sub;
    logic [15:0]   bus_q;
    logic          bus_oe_n;
  } exd_state_t;

  // everything clear, shared bus released
  localparam exd_state_t EXD_RESET = exd_state_t'({{($bits(exd_state_t)-1){1'b0}}, 1'b1});

endpackage

//--- tb/exd_assertions.sv
// port-level checks of the exponent datapath block
`timescale 1ns/1ps
module exd_assertions (
  input wire logic        clock_i,
  input wire logic        sys_rst_i,
  input wire logic [59:0] microword_i,
  input wire logic        time_state_three_i,
  input wire logic        time_state_four_i,
  input wire logic [15:0] cpu_data_in_i,
  input wire logic [15:0] b_side_mux_bus_i,
  input wire logic        op_add_i,
  input wire logic        op_sub_i,
  input wire logic        sign_a_i,
  input wire logic        sign_b_i,
  input wire logic        drive_bus_i,
  input wire logic [15:0] shared_internal_bus_o,
  input wire logic        shared_internal_bus_oe_n_o,
  input wire logic [11:0] fp_instruction_reg_o,
  input wire logic        fraction_subtract_o,
  input wire logic        upper_byte_zero_flag_o,
  input wire logic        word_negative_flag_o,
  input wire logic        word_zero_flag_o,
  input wire logic        match_sync_o,
  input wire logic [5:0]  shift_step_count_o,
  input wire logic        step_done_flag_o,
  input wire logic        step_upper_ones_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  logic ld;
  logic fs;
  assign ld = time_state_four_i && !(microword_i[48] && microword_i[49]);
  assign fs = (op_add_i && sign_a_i != sign_b_i) || (op_sub_i && sign_a_i == sign_b_i);
  a_flags_load: assert property (ld |=>
    word_zero_flag_o == ($past(b_side_mux_bus_i) == 16'h0000)
    && word_negative_flag_o == $past(b_side_mux_bus_i[15])
    && upper_byte_zero_flag_o == ($past(b_side_mux_bus_i[15:8]) == 8'h00))
    else $error("flags do not match loaded word");
  a_flags_hold: assert property (!ld |=> $stable(word_zero_flag_o)
    && $stable(word_negative_flag_o) && $stable(upper_byte_zero_flag_o))
    else $error("flags changed without a load");
  a_instr_load: assert property (time_state_three_i && !microword_i[59] |=>
    fp_instruction_reg_o == $past(cpu_data_in_i[11:0]))
    else $error("instruction not captured");
  a_instr_hold: assert property (!(time_state_three_i && !microword_i[59]) |=>
    $stable(fp_instruction_reg_o)) else $error("instruction changed unexpectedly");
  a_frac_sub: assert property (##1 fraction_subtract_o == $past(fs))
    else $error("subtract decision wrong");
  a_step_done: assert property (step_done_flag_o == (shift_step_count_o == 6'h3F))
    else $error("done flag wrong");
  a_step_upper: assert property (step_upper_ones_o == (&shift_step_count_o[5:2]))
    else $error("upper ones flag wrong");
  a_sync_hold: assert property (!time_state_four_i |=> $stable(match_sync_o))
    else $error("sync changed outside state end");
  a_bus_drive: assert property (drive_bus_i |=> !shared_internal_bus_oe_n_o)
    else $error("bus not driven");
  a_bus_release: assert property (!drive_bus_i |=> shared_internal_bus_oe_n_o
    && shared_internal_bus_o == 16'h0000) else $error("bus not released");
endmodule

bind exd_datapath exd_assertions u_chk (.*);

//--- tb/exd_host_model.sv
// host side of the shared internal bus, open-collector with pull-ups
`timescale 1ns/1ps
module exd_host_model (
  input  wire logic [15:0] dut_bus_i,
  input  wire logic        dut_oe_n_i,
  input  wire logic        host_drive_i,
  input  wire logic [15:0] host_val_i,
  output logic      [15:0] bus_level_o
);
  assign bus_level_o = (dut_oe_n_i ? 16'hFFFF : dut_bus_i)
                     & (host_drive_i ? host_val_i : 16'hFFFF);
endmodule

//--- tb/testbench.sv
// self-checking bench for the exponent datapath block
`timescale 1ns/1ps
`define CHK(g, e) chk(32'(g), 32'(e))
module testbench;
  import exd_pkg::*;
  logic        clock_i = 0, sys_rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0]  wb_adr_i = 0, microaddress_reg_i = 0, decode_rom_a_o, decode_rom_b_o;
  logic [3:0]  wb_sel_i = 4'hF, alu_func_i = 4'hA;
  logic [31:0] wb_dat_i = 0, wb_dat_o, q;
  logic [59:0] microword_i = '1;
  logic exponent_mux_sel_hi_i = 1, exponent_mux_sel_lo_i = 0, alu_mode_i = 1;
  logic alu_carry_n_i = 1, time_state_three_i = 0, time_state_four_i = 0;
  logic time_pulse_four_i = 0, ready_state_i = 0, host_load_a_i = 0, mode_update_i = 0;
  logic microbreak_load_i = 0, step_load_i = 0, step_inc_i = 0, op_add_i = 0, op_sub_i = 0;
  logic sign_a_i = 0, sign_b_i = 0, drive_bus_i = 0, host_drive = 0;
  logic [15:0] exponent_accum_i = 0, cpu_address_mux_lines_i = 0, cpu_data_in_i = 0;
  logic [15:0] b_side_mux_bus_i = 0, host_val = 0, shared_internal_bus_i;
  logic [15:0] shared_internal_bus_o, exponent_alu_o;
  logic [11:0] fp_instruction_reg_o;
  logic [5:0]  shift_step_count_o;
  logic [2:0]  range_code_o;
  logic wb_ack_o, shared_internal_bus_oe_n_o, exponent_alu_carry_o, branch_select_bit5_o;
  logic branch_select_bit6_o, fraction_subtract_o, upper_byte_zero_flag_o;
  logic word_negative_flag_o, word_zero_flag_o, double_precision_flag_o;
  logic long_integer_flag_o, match_request_o, match_sync_o, step_done_flag_o;
  logic step_upper_ones_o, step_preload_hold_o;
  int compares = 0, bad_count = 0;

  exd_datapath #(.DEC_ROM_A_IMAGE({32{8'hFF}}), .DEC_ROM_B_IMAGE({32{8'h40}})) DUT (.*);
  exd_host_model u_host (.dut_bus_i(shared_internal_bus_o),
    .dut_oe_n_i(shared_internal_bus_oe_n_o), .host_drive_i(host_drive),
    .host_val_i(host_val), .bus_level_o(shared_internal_bus_i));

  always #10 clock_i = ~clock_i;

  task automatic tick(input int n = 1);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    tick;
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      tick;
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n == 20) bad_count++;
    q = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
  endtask
  task automatic ts(input bit four);
    if (four) time_state_four_i <= 1;
    else time_state_three_i <= 1;
    tick;
    time_state_four_i <= 0;
    time_state_three_i <= 0;
    tick;
  endtask
  task automatic cfield(input logic [4:0] f);
    exponent_mux_sel_hi_i <= 1;
    exponent_mux_sel_lo_i <= 0;
    microword_i[57:53] <= f;
    tick(2);
  endtask
  function automatic logic [15:0] cexp(input logic [4:0] f);
    case (f)
      5'h00: return 16'h0080;
      5'h09: return 16'h8000;
      5'h0D: return 16'h8004;
      5'h10: return 16'h0090;
      5'h1A: return 16'h0038;
      5'h1B: return 16'h0039;
      5'h1E: return 16'h003C;
      5'h1F: return 16'h003D;
      default: return {11'h000, f};
    endcase
  endfunction
  task automatic end_of_test;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    tick(20000);
    bad_count++;
    end_of_test;
  end

  initial begin
    tick(5);
    sys_rst_i <= 0;
    tick;
    `CHK(shared_internal_bus_oe_n_o, 1);
    for (int f = 0; f < 32; f++) begin
      cfield(5'(f));
      `CHK(exponent_alu_o, cexp(5'(f)));
    end
    b_side_mux_bus_i <= 16'h1234;
    host_load_a_i <= 1;
    tick;
    host_load_a_i <= 0;
    exponent_mux_sel_hi_i <= 0;
    tick(2);
    `CHK(exponent_alu_o, 16'h1234);
    exponent_mux_sel_lo_i <= 1;
    ready_state_i <= 1;
    cpu_address_mux_lines_i <= 16'h00C0;
    cpu_data_in_i <= 16'h0DEF;
    tick(2);
    `CHK(exponent_alu_o, 16'h00C0);
    ready_state_i <= 0;
    tick(2);
    `CHK(exponent_alu_o, 16'h0DEF);
    for (int i = 0; i < 4; i++) begin
      b_side_mux_bus_i <= i[0] ? (i[1] ? 16'h0100 : 16'h8000) : (i[1] ? 16'h00FF : 16'h0000);
      microword_i[49] <= 0;
      ts(1);
      `CHK({upper_byte_zero_flag_o, word_negative_flag_o, word_zero_flag_o},
           i[0] ? (i[1] ? 3'b000 : 3'b010) : (i[1] ? 3'b100 : 3'b101));
    end
    microword_i[49] <= 1;
    wb(0, REG_HOLD_OFF, 0);
    `CHK(q, 32'h0100_1234);
    // load status: long from ALU bit 6, double from bit 7
    exponent_mux_sel_hi_i <= 1;
    exponent_mux_sel_lo_i <= 0;
    cpu_data_in_i <= 16'hF040;
    microword_i[59:53] <= {1'b0, microword_i[58], 5'h00};
    ts(0);
    `CHK(fp_instruction_reg_o, 12'h040);
    ts(0);
    `CHK({branch_select_bit5_o, branch_select_bit6_o, decode_rom_a_o}, 10'h3FF);
    `CHK(decode_rom_b_o, 8'h40);
    microword_i[59] <= 1;
    mode_update_i <= 1;
    ts(1);
    `CHK({double_precision_flag_o, long_integer_flag_o}, 2'b10);
    for (int i = 0; i < 2; i++) begin
      cpu_data_in_i <= i ? 16'hF006 : 16'hF001;
      microword_i[59] <= 0;
      ts(0);
      microword_i[59] <= 1;
      ts(1);
      `CHK({double_precision_flag_o, long_integer_flag_o}, i ? 2'b01 : 2'b00);
    end
    mode_update_i <= 0;
    cpu_data_in_i <= 16'h7040;
    microword_i[59] <= 0;
    ts(0);
    microword_i[59] <= 1;
    tick;
    `CHK({branch_select_bit5_o, branch_select_bit6_o}, 2'b00);
    wb(0, REG_STATUS_OFF, 0);
    `CHK(q[7], 1);
    for (int i = 0; i < 8; i++) begin
      op_add_i <= i[2];
      op_sub_i <= !i[2];
      sign_a_i <= i[1];
      sign_b_i <= i[0];
      tick(2);
      `CHK(fraction_subtract_o, i[2] ? (i[1] != i[0]) : (i[1] == i[0]));
    end
    exponent_mux_sel_lo_i <= 0;
    alu_func_i <= 4'h9;
    alu_mode_i <= 0;
    exponent_accum_i <= 16'hFFFF;
    cfield(5'h01);
    `CHK(exponent_alu_o, 16'h0000);
    `CHK(exponent_alu_carry_o, 1);
    `CHK(range_code_o, 3'h0);
    alu_carry_n_i <= 0;
    tick(2);
    `CHK(exponent_alu_o, 16'h0001);
    `CHK(range_code_o, 3'h1);
    alu_carry_n_i <= 1;
    alu_func_i <= 4'hA;
    alu_mode_i <= 1;
    cfield(5'h02);
    step_load_i <= 1;
    time_pulse_four_i <= 1;
    tick;
    time_pulse_four_i <= 0;
    tick;
    `CHK({step_upper_ones_o, step_done_flag_o, shift_step_count_o}, 8'hBD);
    step_inc_i <= 1;
    tick(2);
    step_inc_i <= 0;
    exponent_mux_sel_lo_i <= 1;
    tick(2);
    `CHK({step_upper_ones_o, step_done_flag_o, shift_step_count_o}, 8'hFF);
    `CHK(exponent_alu_o, 16'h003F);
    `CHK(range_code_o, 3'h3);
    exponent_mux_sel_lo_i <= 0;
    wb(1, REG_CTRL_OFF, 1);
    wb(1, REG_STEP_OFF, 32'h05);
    wb(0, REG_STEP_OFF, 0);
    `CHK(q, 32'h13A);
    `CHK(step_preload_hold_o, 1);
    time_pulse_four_i <= 1;
    tick;
    time_pulse_four_i <= 0;
    step_inc_i <= 1;
    tick(5);
    step_inc_i <= 0;
    wb(0, REG_STEP_OFF, 0);
    `CHK(q, 32'h0FF);
    wb(1, REG_CTRL_OFF, 0);
    wb(1, REG_STEP_OFF, 32'h3F);
    wb(0, REG_STEP_OFF, 0);
    `CHK(q, 32'h000);
    step_load_i <= 0;
    cfield(5'h0A);
    microbreak_load_i <= 1;
    microaddress_reg_i <= 8'h0A;
    tick;
    microbreak_load_i <= 0;
    tick(2);
    `CHK(match_request_o, 1);
    ts(1);
    microaddress_reg_i <= 8'h0B;
    tick(2);
    `CHK({match_request_o, match_sync_o}, 2'b01);
    ts(1);
    `CHK(match_sync_o, 0);
    wb(0, 8'h3C, 0);
    `CHK(q, 0);
    drive_bus_i <= 1;
    host_drive <= 1;
    host_val <= 16'h00FF;
    tick(2);
    `CHK(shared_internal_bus_o, 16'h0100);
    wb(0, REG_INSTR_OFF, 0);
    `CHK(q[31:16], 16'h0000);
    drive_bus_i <= 0;
    wb(0, REG_INSTR_OFF, 0);
    `CHK(q[31:16], 16'h00FF);
    end_of_test;
  end
endmodule
